/* design/ots_pkg.sv */
/*
 * constants, register map and selection codes for the output terminal status selector.
 * assumes a 100 MHz system clock and an APB master with 32-bit data.
 */
// Contract
// - code 13 asserts terminal while output frequency within reference plus/minus width.
// - code 13 compares magnitudes, so it works in both rotation directions.
// - code 14 needs frequency inside level window and inside reference window.
// - codes 14, 15, 16 use signed level, detecting only in its direction.
// - code 15 drops above level plus width, stays off until back at level.
// - code 16 asserts above level, stays on until level minus width.
// - code 18 asserts on torque above level, or below it beyond detect time.
// - code 1A asserts while running reverse, off when forward or stopped.
// - code 1B is low during baseblock, high otherwise.
// - code 1E asserts while auto restart is attempting a restart.
// - code 1F asserts when thermal accumulator reaches 90 percent of level.
// - code 20 asserts when heatsink temperature reaches alarm level.
// - code 21 asserts when both safe inputs open and safety circuits healthy.
// - code F leaves the terminal unused and undriven by any function.
// - codes 100 to 158 output inverse of function named by last digits.
package ots_pkg;
	// ----------------------------------------------------------------
	// widths
	// ----------------------------------------------------------------
	localparam int FREQ_W     = 16;
	localparam int TORQUE_W   = 16;
	localparam int THERM_W    = 16;
	localparam int TEMP_W     = 12;
	localparam int SEL_W      = 12;
	localparam int ADDR_W     = 8;
	localparam int DATA_W     = 32;
	localparam int TQ_CNT_W   = 16;
	localparam int TICK_CNT_W = 24;
	localparam int INT_W      = 2;
	localparam int ST_W       = 5;

	// ----------------------------------------------------------------
	// selection codes
	// ----------------------------------------------------------------
	localparam logic [SEL_W-1:0] SEL_UNUSED     = 12'h00F;
	localparam logic [SEL_W-1:0] SEL_SPEED_AGR  = 12'h013;
	localparam logic [SEL_W-1:0] SEL_USER_AGR   = 12'h014;
	localparam logic [SEL_W-1:0] SEL_FREQ_DET3  = 12'h015;
	localparam logic [SEL_W-1:0] SEL_FREQ_DET4  = 12'h016;
	localparam logic [SEL_W-1:0] SEL_TORQUE2    = 12'h018;
	localparam logic [SEL_W-1:0] SEL_REVERSE    = 12'h01A;
	localparam logic [SEL_W-1:0] SEL_BB_NC      = 12'h01B;
	localparam logic [SEL_W-1:0] SEL_RESTART    = 12'h01E;
	localparam logic [SEL_W-1:0] SEL_MOTOR_OL   = 12'h01F;
	localparam logic [SEL_W-1:0] SEL_HEATSINK   = 12'h020;
	localparam logic [SEL_W-1:0] SEL_SAFE_OFF   = 12'h021;
	localparam logic [SEL_W-1:0] SEL_INV_FIRST  = 12'h100;
	localparam logic [SEL_W-1:0] SEL_INV_LAST   = 12'h158;

	// ----------------------------------------------------------------
	// overload ratio: accum * den >= level * num
	// ----------------------------------------------------------------
	localparam logic [3:0] OL_PCT_NUM = 4'h9;
	localparam logic [3:0] OL_PCT_DEN = 4'hA;

	// ----------------------------------------------------------------
	// timing: torque detect time counts in 1 ms ticks
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 10;
	localparam int TQ_TICK_NS    = 1000000;
	localparam int TQ_TICK_CYC   = TQ_TICK_NS / CLK_PERIOD_NS;

	// ----------------------------------------------------------------
	// register byte offsets
	// ----------------------------------------------------------------
	localparam logic [ADDR_W-1:0] OFF_SEL      = 8'h00;
	localparam logic [ADDR_W-1:0] OFF_LEVEL    = 8'h04;
	localparam logic [ADDR_W-1:0] OFF_WIDTH    = 8'h08;
	localparam logic [ADDR_W-1:0] OFF_TQ_LEVEL = 8'h0C;
	localparam logic [ADDR_W-1:0] OFF_TQ_TIME  = 8'h10;
	localparam logic [ADDR_W-1:0] OFF_HS_LEVEL = 8'h14;
	localparam logic [ADDR_W-1:0] OFF_OL_LEVEL = 8'h18;
	localparam logic [ADDR_W-1:0] OFF_STATE    = 8'h1C;
	localparam logic [ADDR_W-1:0] OFF_INT_STS  = 8'h20;
	localparam logic [ADDR_W-1:0] OFF_INT_MASK = 8'h24;

	// ----------------------------------------------------------------
	// field positions and reset values
	// ----------------------------------------------------------------
	localparam int INT_RISE_BIT = 0;
	localparam int INT_FALL_BIT = 1;
	localparam int ST_TERM_BIT  = 0;
	localparam int ST_TRIP_BIT  = 1;
	localparam int ST_ACT_BIT   = 2;
	localparam int ST_SAFE_A    = 3;
	localparam int ST_SAFE_B    = 4;
	localparam logic [SEL_W-1:0]    RST_SEL   = SEL_UNUSED;
	localparam logic [FREQ_W-1:0]   RST_FREQ  = 16'h0000;
	localparam logic [TORQUE_W-1:0] RST_TQ    = 16'h0000;
	localparam logic [TQ_CNT_W-1:0] RST_TQ_T  = 16'h0000;
	localparam logic [TEMP_W-1:0]   RST_TEMP  = 12'hFFF;
	localparam logic [THERM_W-1:0]  RST_OL    = 16'hFFFF;
	localparam logic [INT_W-1:0]    RST_INT   = 2'h0;
endpackage

/* design/ots_sync.sv */
/*
 * three-stage synchroniser for pin inputs with agreement filter.
 * assumes an active-low asynchronous reset already synchronised to clk.
 */
`timescale 1ns/1ps
module ots_sync #(
	parameter int W = 1
) (
	input  wire logic         clk,     // system clock
	input  wire logic         rst_n,   // synchronised reset, active low
	input  wire logic [W-1:0] pin_in,  // raw pin levels
	output logic      [W-1:0] level_q  // filtered level
);
	logic [W-1:0] s1_q;
	logic [W-1:0] s2_q;
	logic [W-1:0] s3_q;
	logic [W-1:0] level_d;

	// a bit changes only once stages two and three agree
	always_comb begin
		for (int i = 0; i < W; i++) begin
			level_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : level_q[i];
		end
	end

	// shift chain and filtered level
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s1_q    <= '0;
			s2_q    <= '0;
			s3_q    <= '0;
			level_q <= '0;
		end else begin
			s1_q    <= pin_in;
			s2_q    <= s1_q;
			s3_q    <= s2_q;
			level_q <= level_d;
		end
	end
endmodule

/* design/ots_window.sv */
/*
 * unsigned window compare: value lies in center plus/minus width.
 * assumes magnitudes, no sign; one extra bit keeps the sums exact.
 */
`timescale 1ns/1ps
module ots_window #(
	parameter int W = 16
) (
	input  wire logic [W-1:0] value,   // magnitude under test
	input  wire logic [W-1:0] center,  // window centre
	input  wire logic [W-1:0] width,   // half width
	output logic              in_win   // value inside window
);
	logic [W:0] lo_sum;
	logic [W:0] hi_sum;

	// compare with both bounds, no wrap
	assign lo_sum = {1'b0, value} + {1'b0, width};
	assign hi_sum = {1'b0, center} + {1'b0, width};
	assign in_win = (lo_sum >= {1'b0, center}) && ({1'b0, value} <= hi_sum);
endmodule

/* design/ots_top.sv */
/*
 * output terminal status selector: one digital output terminal whose meaning is picked
 * by a selection code, with APB register access and a level interrupt.
 * assumes drive quantities arrive on clk already; the safe inputs come from pins.
 */
`timescale 1ns/1ps
module ots_top #(
	parameter int TQ_TICK_CYCLES = ots_pkg::TQ_TICK_CYC
) (
	input  wire logic                                clk,                          // 100 MHz clock
	input  wire logic                                rst_n,                        // async reset, active low
	input  wire logic                                psel,                         // apb select
	input  wire logic                                penable,                      // apb enable
	input  wire logic                                pwrite,                       // apb write
	input  wire logic [ots_pkg::ADDR_W-1:0]          paddr,                        // apb byte address
	input  wire logic [ots_pkg::DATA_W-1:0]          pwdata,                       // apb write data
	output logic      [ots_pkg::DATA_W-1:0]          prdata,                       // apb read data
	output logic                                     pready,                       // apb ready
	output logic                                     pslverr,                      // apb error
	input  wire logic signed [ots_pkg::FREQ_W-1:0]   out_freq,                     // output frequency
	input  wire logic signed [ots_pkg::FREQ_W-1:0]   freq_ref,                     // frequency reference
	input  wire logic [ots_pkg::TORQUE_W-1:0]        torque,                       // current or torque
	input  wire logic                                motor_reverse,                // running reverse
	input  wire logic                                baseblock,                    // switching halted
	input  wire logic                                auto_restart_active,          // restart attempt
	input  wire logic [ots_pkg::THERM_W-1:0]         thermal_accum,                // motor thermal value
	input  wire logic [ots_pkg::TEMP_W-1:0]          heatsink_temp,                // heatsink temperature
	input  wire logic                                safety_ok,                    // safety circuit good
	input  wire logic                                diag_ok,                      // diagnosis circuit good
	input  wire logic                                safe_disable_input_a,         // pin, high when closed
	input  wire logic                                safe_disable_input_b,         // pin, high when closed
	output logic                                     multi_function_digital_output, // terminal state
	output logic                                     irq                           // level interrupt
);
	localparam int FW = ots_pkg::FREQ_W;
	localparam int TW = ots_pkg::TICK_CNT_W;
	localparam int PW = ots_pkg::THERM_W + 4;

	// ----------------------------------------------------------------
	// reset release
	// ----------------------------------------------------------------
	logic rst_s1_q;
	logic rst_sync_n;

	// two-stage release, async assert
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_s1_q   <= 1'b0;
			rst_sync_n <= 1'b0;
		end else begin
			rst_s1_q   <= 1'b1;
			rst_sync_n <= rst_s1_q;
		end
	end

	// ----------------------------------------------------------------
	// pin inputs and magnitudes
	// ----------------------------------------------------------------
	logic [1:0]    safe_lvl;
	logic [FW-1:0] f_mag;
	logic [FW-1:0] r_mag;
	logic [FW-1:0] l_mag;

	ots_sync #(.W(2)) u_safe_sync (
		.clk     (clk),
		.rst_n   (rst_sync_n),
		.pin_in  ({safe_disable_input_b, safe_disable_input_a}),
		.level_q (safe_lvl)
	);

	function automatic logic [FW-1:0] mag(input logic signed [FW-1:0] v);
		mag = v[FW-1] ? FW'(-v) : FW'(v);
	endfunction

	// ----------------------------------------------------------------
	// registers and apb slave
	// ----------------------------------------------------------------
	logic [ots_pkg::SEL_W-1:0]    sel_q, sel_d, sel_prev_q;
	logic signed [FW-1:0]         lvl_q, lvl_d;
	logic [FW-1:0]                wid_q, wid_d;
	logic [ots_pkg::TORQUE_W-1:0] tql_q, tql_d;
	logic [ots_pkg::TQ_CNT_W-1:0] tqt_q, tqt_d;
	logic [ots_pkg::TEMP_W-1:0]   hsl_q, hsl_d;
	logic [ots_pkg::THERM_W-1:0]  oll_q, oll_d;
	logic [ots_pkg::INT_W-1:0]    sts_q, sts_d, msk_q, msk_d;
	logic [ots_pkg::DATA_W-1:0]   rdata, prdata_d;
	logic [ots_pkg::ST_W-1:0]     state_vec;
	logic                         pready_d, pslverr_d, irq_d, wr_en, mapped;
	logic [ots_pkg::INT_W-1:0]    events;

	assign wr_en = psel && penable && pwrite && pready;

	// read mux and address decode
	always_comb begin
		rdata  = '0;
		mapped = 1'b1;
		unique case (paddr)
			ots_pkg::OFF_SEL:      rdata = 32'(sel_q);
			ots_pkg::OFF_LEVEL:    rdata = 32'(unsigned'(lvl_q));
			ots_pkg::OFF_WIDTH:    rdata = 32'(wid_q);
			ots_pkg::OFF_TQ_LEVEL: rdata = 32'(tql_q);
			ots_pkg::OFF_TQ_TIME:  rdata = 32'(tqt_q);
			ots_pkg::OFF_HS_LEVEL: rdata = 32'(hsl_q);
			ots_pkg::OFF_OL_LEVEL: rdata = 32'(oll_q);
			ots_pkg::OFF_STATE:    rdata = 32'(state_vec);
			ots_pkg::OFF_INT_STS:  rdata = 32'(sts_q);
			ots_pkg::OFF_INT_MASK: rdata = 32'(msk_q);
			default:               mapped = 1'b0;
		endcase
	end

	// next register values; one wait state per access
	always_comb begin
		sel_d     = sel_q;
		lvl_d     = lvl_q;
		wid_d     = wid_q;
		tql_d     = tql_q;
		tqt_d     = tqt_q;
		hsl_d     = hsl_q;
		oll_d     = oll_q;
		msk_d     = msk_q;
		sts_d     = sts_q;
		pready_d  = psel && penable && !pready;
		pslverr_d = pready_d && !mapped;
		prdata_d  = pready_d ? rdata : prdata;
		if (wr_en && mapped) begin
			unique case (paddr)
				ots_pkg::OFF_SEL:      sel_d = pwdata[ots_pkg::SEL_W-1:0];
				ots_pkg::OFF_LEVEL:    lvl_d = signed'(pwdata[FW-1:0]);
				ots_pkg::OFF_WIDTH:    wid_d = pwdata[FW-1:0];
				ots_pkg::OFF_TQ_LEVEL: tql_d = pwdata[ots_pkg::TORQUE_W-1:0];
				ots_pkg::OFF_TQ_TIME:  tqt_d = pwdata[ots_pkg::TQ_CNT_W-1:0];
				ots_pkg::OFF_HS_LEVEL: hsl_d = pwdata[ots_pkg::TEMP_W-1:0];
				ots_pkg::OFF_OL_LEVEL: oll_d = pwdata[ots_pkg::THERM_W-1:0];
				ots_pkg::OFF_INT_STS:  sts_d = sts_q & ~pwdata[ots_pkg::INT_W-1:0];
				ots_pkg::OFF_INT_MASK: msk_d = pwdata[ots_pkg::INT_W-1:0];
				default:               sel_d = sel_q;
			endcase
		end
		sts_d = sts_d | events;  // set wins over clear
		irq_d = |(sts_q & msk_q);
	end

	always_ff @(posedge clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			sel_q      <= ots_pkg::RST_SEL;
			sel_prev_q <= ots_pkg::RST_SEL;
			lvl_q      <= signed'(ots_pkg::RST_FREQ);
			wid_q      <= ots_pkg::RST_FREQ;
			tql_q      <= ots_pkg::RST_TQ;
			tqt_q      <= ots_pkg::RST_TQ_T;
			hsl_q      <= ots_pkg::RST_TEMP;
			oll_q      <= ots_pkg::RST_OL;
			sts_q      <= ots_pkg::RST_INT;
			msk_q      <= ots_pkg::RST_INT;
			pready     <= 1'b0;
			pslverr    <= 1'b0;
			prdata     <= '0;
			irq        <= 1'b0;
		end else begin
			sel_q      <= sel_d;
			sel_prev_q <= sel_q;
			lvl_q      <= lvl_d;
			wid_q      <= wid_d;
			tql_q      <= tql_d;
			tqt_q      <= tqt_d;
			hsl_q      <= hsl_d;
			oll_q      <= oll_d;
			sts_q      <= sts_d;
			msk_q      <= msk_d;
			pready     <= pready_d;
			pslverr    <= pslverr_d;
			prdata     <= prdata_d;
			irq        <= irq_d;
		end
	end

	// ----------------------------------------------------------------
	// frequency detection
	// ----------------------------------------------------------------
	logic ref_win, lvl_win, dir_ok, sel_chg;
	logic trip_q, trip_d, act_q, act_d;
	logic [FW:0] lvl_hi;
	logic [FW-1:0] lvl_lo;

	assign f_mag   = mag(out_freq);
	assign r_mag   = mag(freq_ref);
	assign l_mag   = mag(lvl_q);
	assign sel_chg = (sel_q != sel_prev_q);
	assign dir_ok  = (out_freq != '0) && (out_freq[FW-1] == lvl_q[FW-1]);
	assign lvl_hi  = {1'b0, l_mag} + {1'b0, wid_q};
	assign lvl_lo  = (l_mag > wid_q) ? (l_mag - wid_q) : '0;

	ots_window #(.W(FW)) u_ref_win (
		.value  (f_mag),
		.center (r_mag),
		.width  (wid_q),
		.in_win (ref_win)
	);

	ots_window #(.W(FW)) u_lvl_win (
		.value  (f_mag),
		.center (l_mag),
		.width  (wid_q),
		.in_win (lvl_win)
	);

	// hysteresis for the two threshold detectors
	always_comb begin
		trip_d = trip_q;
		act_d  = act_q;
		if (!dir_ok || f_mag <= l_mag) begin
			trip_d = 1'b0;
		end else if ({1'b0, f_mag} > lvl_hi) begin
			trip_d = 1'b1;
		end
		if (!dir_ok || f_mag <= lvl_lo) begin
			act_d = 1'b0;
		end else if (f_mag > l_mag) begin
			act_d = 1'b1;
		end
		if (sel_chg) begin
			trip_d = 1'b0;
			act_d  = 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			trip_q <= 1'b0;
			act_q  <= 1'b0;
		end else begin
			trip_q <= trip_d;
			act_q  <= act_d;
		end
	end

	// ----------------------------------------------------------------
	// torque detection with millisecond tick
	// ----------------------------------------------------------------
	logic [TW-1:0]                tick_q, tick_d;
	logic [ots_pkg::TQ_CNT_W-1:0] ucnt_q, ucnt_d;
	logic                         tick_en, tq_over, tq_under, tq_det;

	assign tick_en  = (tick_q == TW'(TQ_TICK_CYCLES - 1));
	assign tq_over  = torque > tql_q;
	assign tq_under = torque < tql_q;
	assign tq_det   = tq_over || (tq_under && ucnt_q > tqt_q);

	// count ticks spent below level, saturating
	always_comb begin
		tick_d = tick_en ? '0 : tick_q + TW'(1);
		ucnt_d = ucnt_q;
		if (!tq_under) begin
			ucnt_d = '0;
		end else if (tick_en && ucnt_q != '1) begin
			ucnt_d = ucnt_q + ots_pkg::TQ_CNT_W'(1);
		end
	end

	always_ff @(posedge clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			tick_q <= '0;
			ucnt_q <= '0;
		end else begin
			tick_q <= tick_d;
			ucnt_q <= ucnt_d;
		end
	end

	// ----------------------------------------------------------------
	// function select and terminal
	// ----------------------------------------------------------------
	logic [PW-1:0]              th_scaled, ol_scaled;
	logic [ots_pkg::SEL_W-1:0]  base;
	logic                       inv, func, term_d, safe_off;

	assign th_scaled = PW'(thermal_accum) * PW'(ots_pkg::OL_PCT_DEN);
	assign ol_scaled = PW'(oll_q) * PW'(ots_pkg::OL_PCT_NUM);
	assign safe_off  = !safe_lvl[0] && !safe_lvl[1] && safety_ok && diag_ok;
	assign inv       = (sel_q >= ots_pkg::SEL_INV_FIRST) && (sel_q <= ots_pkg::SEL_INV_LAST);
	assign base      = inv ? (sel_q - ots_pkg::SEL_INV_FIRST) : sel_q;
	assign state_vec = {safe_lvl[1], safe_lvl[0], act_q, trip_q, multi_function_digital_output};
	assign events    = {!term_d && multi_function_digital_output, term_d && !multi_function_digital_output};

	// pick the selected condition
	always_comb begin
		unique case (base)
			ots_pkg::SEL_SPEED_AGR: func = ref_win;
			ots_pkg::SEL_USER_AGR:  func = dir_ok && lvl_win && ref_win;
			ots_pkg::SEL_FREQ_DET3: func = !trip_q;
			ots_pkg::SEL_FREQ_DET4: func = act_q;
			ots_pkg::SEL_TORQUE2:   func = tq_det;
			ots_pkg::SEL_REVERSE:   func = motor_reverse;
			ots_pkg::SEL_BB_NC:     func = !baseblock;
			ots_pkg::SEL_RESTART:   func = auto_restart_active;
			ots_pkg::SEL_MOTOR_OL:  func = th_scaled >= ol_scaled;
			ots_pkg::SEL_HEATSINK:  func = heatsink_temp >= hsl_q;
			ots_pkg::SEL_SAFE_OFF:  func = safe_off;
			default:                func = 1'b0;
		endcase
		term_d = inv ? !func : func;
		if (sel_q > ots_pkg::SEL_INV_LAST) begin
			term_d = 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			multi_function_digital_output <= 1'b0;
		end else begin
			multi_function_digital_output <= term_d;
		end
	end

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	property p_reverse;
		@(posedge clk) disable iff (!rst_sync_n)
		(sel_q == ots_pkg::SEL_REVERSE) |=> (multi_function_digital_output == $past(motor_reverse));
	endproperty
	a_reverse: assert property (p_reverse) else $error("reverse code mismatch");

	property p_baseblock;
		@(posedge clk) disable iff (!rst_sync_n)
		(sel_q == ots_pkg::SEL_BB_NC) && baseblock |=> !multi_function_digital_output;
	endproperty
	a_baseblock: assert property (p_baseblock) else $error("terminal high in baseblock");

	property p_unused;
		@(posedge clk) disable iff (!rst_sync_n)
		(sel_q == ots_pkg::SEL_UNUSED) [*2] |=> !multi_function_digital_output;
	endproperty
	a_unused: assert property (p_unused) else $error("unused terminal driven");

	property p_inverse;
		@(posedge clk) disable iff (!rst_sync_n)
		(sel_q == (ots_pkg::SEL_INV_FIRST | ots_pkg::SEL_REVERSE)) && motor_reverse
			|=> !multi_function_digital_output;
	endproperty
	a_inverse: assert property (p_inverse) else $error("inverse reverse not low");

	property p_restart;
		@(posedge clk) disable iff (!rst_sync_n)
		(sel_q == ots_pkg::SEL_RESTART) && auto_restart_active |=> multi_function_digital_output;
	endproperty
	a_restart: assert property (p_restart) else $error("restart not shown");

	property p_speed_out;
		@(posedge clk) disable iff (!rst_sync_n)
		(sel_q == ots_pkg::SEL_SPEED_AGR) && ({1'b0, f_mag} > ({1'b0, r_mag} + {1'b0, wid_q}))
			|=> !multi_function_digital_output;
	endproperty
	a_speed_out: assert property (p_speed_out) else $error("speed agree outside window");

	property p_hyst_clear;
		@(posedge clk) disable iff (!rst_sync_n)
		$changed(sel_q) |=> (!trip_q && !act_q);
	endproperty
	a_hyst_clear: assert property (p_hyst_clear) else $error("hysteresis not cleared");

	property p_safe;
		@(posedge clk) disable iff (!rst_sync_n)
		(sel_q == ots_pkg::SEL_SAFE_OFF) && (!safety_ok || !diag_ok || safe_lvl[0] || safe_lvl[1])
			|=> !multi_function_digital_output;
	endproperty
	a_safe: assert property (p_safe) else $error("safe off shown without cause");

	property p_heat;
		@(posedge clk) disable iff (!rst_sync_n)
		(sel_q == ots_pkg::SEL_HEATSINK) && (heatsink_temp >= hsl_q) |=> multi_function_digital_output;
	endproperty
	a_heat: assert property (p_heat) else $error("heatsink alarm missing");
endmodule

/* dv/ots_term_reader.sv */
/*
 * terminal reader model: the external controller latching the output terminal.
 * assumes the terminal is a registered level on the same clock.
 */
`timescale 1ns/1ps
module ots_term_reader (
	input  wire logic clk,    // controller sample clock
	input  wire logic term,   // terminal level
	output logic      seen_q  // latched terminal level
);
	// latch the terminal once per clock
	always_ff @(posedge clk) begin
		seen_q <= term;
	end
endmodule

/* dv/ots_top_tb_top.sv */
/*
 * testbench for the output terminal status selector: apb tasks and terminal checks.
 * assumes the design package and the terminal reader model are compiled first.
 */
`timescale 1ns/1ps
`define CHK(n, e, a) begin checks_done++; if ((a) !== (e)) begin fail_count++; $display("unexpected %s exp %0h got %0h", n, e, a); end end
module ots_top_tb_top;
	logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, irq, seen, er;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic signed [15:0] out_freq = 16'h0000, freq_ref = 16'h0000;
	logic [15:0] torque = 16'h0000, thermal_accum = 16'h0000;
	logic [11:0] heatsink_temp = 12'h000;
	logic motor_reverse = 1'b0, baseblock = 1'b0, auto_restart_active = 1'b0, safety_ok = 1'b1, diag_ok = 1'b1;
	logic safe_disable_input_a = 1'b1, safe_disable_input_b = 1'b1, multi_function_digital_output;
	int fail_count = 0, checks_done = 0;

	ots_top #(.TQ_TICK_CYCLES(4)) u_ots_top (
		.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .out_freq(out_freq),
		.freq_ref(freq_ref), .torque(torque), .motor_reverse(motor_reverse), .baseblock(baseblock),
		.auto_restart_active(auto_restart_active), .thermal_accum(thermal_accum),
		.heatsink_temp(heatsink_temp), .safety_ok(safety_ok), .diag_ok(diag_ok),
		.safe_disable_input_a(safe_disable_input_a), .safe_disable_input_b(safe_disable_input_b),
		.multi_function_digital_output(multi_function_digital_output), .irq(irq)
	);
	ots_term_reader u_ots_term_reader (.clk(clk), .term(multi_function_digital_output), .seen_q(seen));

	// clock and watchdog
	always #5 clk = ~clk;
	initial begin
		#100000;
		fail_count++;
		end_sim();
	end

	// one apb transfer, held until pready is sampled high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		{psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// settle, then compare the latched terminal
	task automatic wchk(input logic e);
		repeat (8) @(posedge clk);
		`CHK("term", e, seen)
	endtask

	// select a code, check it, then check its inverse code
	task automatic tc(input logic [11:0] s, input logic e);
		apb(1'b1, ots_pkg::OFF_SEL, {20'h0, s});
		wchk(e);
		apb(1'b1, ots_pkg::OFF_SEL, {20'h0, s | 12'h100});
		wchk(~e);
	endtask

	task automatic end_sim();
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// test sequence
	initial begin
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge clk);
		apb(1'b0, ots_pkg::OFF_SEL, 32'h0);
		`CHK("sel", 32'h0000000F, rd)
		`CHK("term", 1'b0, seen)
		apb(1'b0, 8'h40, 32'h0);
		`CHK("err", 1'b1, er)
		apb(1'b1, ots_pkg::OFF_INT_MASK, 32'h1);
		motor_reverse <= 1'b1;
		tc(12'h01A, 1'b1);
		apb(1'b0, ots_pkg::OFF_INT_STS, 32'h0);
		`CHK("sts", 32'h3, rd)
		`CHK("irq", 1'b1, irq)
		apb(1'b1, ots_pkg::OFF_INT_STS, 32'h3);
		apb(1'b0, ots_pkg::OFF_INT_STS, 32'h0);
		`CHK("sts", 32'h0, rd)
		`CHK("irq", 1'b0, irq)
		motor_reverse <= 1'b0;
		tc(12'h01A, 1'b0);
		baseblock <= 1'b1;
		tc(12'h01B, 1'b0);
		baseblock <= 1'b0;
		auto_restart_active <= 1'b1;
		tc(12'h01B, 1'b1);
		tc(12'h01E, 1'b1);
		apb(1'b1, ots_pkg::OFF_OL_LEVEL, 32'h64);
		thermal_accum <= 16'h005A;
		tc(12'h01F, 1'b1);
		thermal_accum <= 16'h0059;
		tc(12'h01F, 1'b0);
		apb(1'b1, ots_pkg::OFF_HS_LEVEL, 32'h32);
		heatsink_temp <= 12'h032;
		tc(12'h020, 1'b1);
		heatsink_temp <= 12'h031;
		tc(12'h020, 1'b0);
		{safe_disable_input_a, safe_disable_input_b} <= 2'b00;
		tc(12'h021, 1'b1);
		diag_ok <= 1'b0;
		tc(12'h021, 1'b0);
		{safety_ok, diag_ok} <= 2'b01;
		tc(12'h021, 1'b0);
		apb(1'b1, ots_pkg::OFF_TQ_LEVEL, 32'h64);
		apb(1'b1, ots_pkg::OFF_TQ_TIME, 32'h2);
		torque <= 16'h0065;
		tc(12'h018, 1'b1);
		torque <= 16'h0064;
		tc(12'h018, 1'b0);
		torque <= 16'h0032;
		repeat (20) @(posedge clk);
		tc(12'h018, 1'b1);
		apb(1'b1, ots_pkg::OFF_WIDTH, 32'hA);
		apb(1'b1, ots_pkg::OFF_LEVEL, 32'h64);
		{freq_ref, out_freq} <= {16'h0064, 16'hFF97};
		tc(12'h013, 1'b1);
		out_freq <= 16'h006F;
		tc(12'h013, 1'b0);
		out_freq <= 16'h0069;
		tc(12'h014, 1'b1);
		freq_ref <= 16'h0078;
		tc(12'h014, 1'b0);
		{freq_ref, out_freq} <= {16'hFF9C, 16'hFF97};
		tc(12'h014, 1'b0);
		apb(1'b1, ots_pkg::OFF_SEL, 32'h016);
		out_freq <= 16'h0069;
		wchk(1'b1);
		out_freq <= 16'h005F;
		wchk(1'b1);
		out_freq <= 16'h0059;
		wchk(1'b0);
		apb(1'b1, ots_pkg::OFF_SEL, 32'h015);
		out_freq <= 16'h0073;
		wchk(1'b0);
		out_freq <= 16'h0069;
		wchk(1'b0);
		out_freq <= 16'h0064;
		wchk(1'b1);
		out_freq <= 16'h0073;
		wchk(1'b0);
		out_freq <= 16'h0069;
		apb(1'b1, ots_pkg::OFF_SEL, 32'h016);
		tc(12'h015, 1'b1);
		apb(1'b1, ots_pkg::OFF_SEL, 32'h01B);
		wchk(1'b1);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		`CHK("term", 1'b0, multi_function_digital_output)
		`CHK("irq", 1'b0, irq)
		end_sim();
	end
endmodule
